// file: hw/spi_unit.sv
// spi_unit: master/slave serial unit with seven pins, each switchable to plain pin I/O.
// assumes an AXI4-Lite master on aclk and external pins that are asynchronous to aclk.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spi_unit
  import spi_unit_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [6:0] pin_i,
  output logic [6:0] pin_o,
  output logic [6:0] pin_oe_n,
  output logic xfer_req_tx,
  output logic xfer_req_rx
);

  typedef struct packed {
    logic aw_have;
    logic [11:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [6:0] pin_io;
    logic [6:0] drive;
    logic [6:0] level;
    logic [6:0] od;
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] sync3;
    logic [6:0] pin_o;
    logic [6:0] pin_oe_n;
    logic [GATE_W-1:0] gate;
    logic [IRQ_W-1:0] irq_mask;
    mode_s mode;
    sel_cfg_s [3:0] cfg;
    logic en;
    logic fault;
    logic ovr;
    logic rx_full;
    logic tx_full;
    logic [15:0] tx_data;
    logic [3:0] tx_cs;
    logic [15:0] rx_data;
    logic [3:0] rx_sel;
    xfer_e xs;
    logic [3:0] sel;
    logic [1:0] cfg_idx;
    logic [15:0] sh;
    logic [15:0] rsh;
    logic [5:0] edges;
    logic [7:0] cnt;
    logic [4:0] pre;
    logic sck;
    logic [2:0] sel0_hist;
    logic req_tx;
    logic req_rx;
  } st_s;

  st_s q;
  st_s d;

  function automatic logic mapped(input logic [11:0] a);
    case ({a[11:2], 2'b00})
      OFF_PIN_IO_EN, OFF_PIN_IO_DIS, OFF_PIN_IO_ST, OFF_DRIVE_EN, OFF_DRIVE_DIS, OFF_DRIVE_ST,
      OFF_LEVEL_SET, OFF_LEVEL_CLR, OFF_LEVEL_ST, OFF_INPUT_ST, OFF_OD_EN, OFF_OD_DIS, OFF_OD_ST,
      OFF_GATE_EN, OFF_GATE_DIS, OFF_GATE_ST, OFF_CONTROL, OFF_MODE, OFF_STATUS, OFF_IRQ_EN,
      OFF_IRQ_DIS, OFF_IRQ_ST, OFF_RX_WORD, OFF_TX_WORD: mapped = 1'b1;
      default: mapped = ({a[11:2], 2'b00} >= OFF_CFG0) && ({a[11:2], 2'b00} <= OFF_CFG3);
    endcase
  endfunction

  function automatic logic [31:0] byte_mask(input logic [3:0] s);
    byte_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic [4:0] word_bits(input sel_cfg_s c);
    word_bits = (c.bits > 4'd8) ? 5'(BITS_MAX) : 5'(BITS_BASE) + {1'b0, c.bits};
  endfunction

  // individual selects: the lowest low line picks the config; decoded: four peripherals per config
  function automatic logic [1:0] cfg_index(input logic [3:0] cs, input logic dec);
    if (dec) begin
      cfg_index = cs[3:2];
    end else if (!cs[0]) begin
      cfg_index = 2'd0;
    end else if (!cs[1]) begin
      cfg_index = 2'd1;
    end else if (!cs[2]) begin
      cfg_index = 2'd2;
    end else begin
      cfg_index = 2'd3;
    end
  endfunction

  logic wr_go;
  logic rd_go;
  logic [11:0] wa;
  logic [11:0] ra;
  logic [31:0] wv;
  logic [31:0] rv;
  logic [6:0] w_pins;
  logic rx_read;
  logic tick;
  logic fault_now;
  logic word_done;
  logic edge_now;
  logic sample;
  logic rx_in;
  sel_cfg_s cur;
  sel_cfg_s ncfg;
  logic [4:0] nb;
  logic [7:0] half;
  logic [3:0] cs_new;
  logic [15:0] rsh_new;
  logic [6:0] fn_o;
  logic [6:0] fn_drv;
  logic o_v;
  logic drv_v;

  always_comb begin
    d = q;
    wa = {q.aw_addr[11:2], 2'b00};
    ra = {araddr[11:2], 2'b00};
    wv = q.w_data & byte_mask(q.w_strb);
    w_pins = wv[PIN_LSB +: 7];
    wr_go = q.aw_have && q.w_have && !q.bvalid;
    rd_go = arvalid && q.arready;
    rx_read = rd_go && (ra == OFF_RX_WORD);
    rv = 32'h00000000;
    tick = q.mode.clock_divider_bit ? (q.pre == 5'(DIV_RATIO - 1)) : 1'b1;
    cur = q.cfg[q.xs == X_SLAVE ? 2'd0 : q.cfg_idx];
    nb = word_bits(cur);
    half = (cur.baud == 8'h00) ? 8'h01 : cur.baud;
    cs_new = q.mode.ps ? q.tx_cs : q.mode.cs;
    ncfg = q.cfg[cfg_index(cs_new, q.mode.decode)];
    word_done = 1'b0;
    edge_now = 1'b0;
    rx_in = q.mode.master ? q.sync2[PIN_MISO] : q.sync2[PIN_MOSI];
    sample = cur.clock_phase_field ? !q.edges[0] : q.edges[0];
    rsh_new = q.rsh;
    // the lag through pin register and synchroniser is three cycles, hence the history
    fault_now = q.mode.master && q.en && !q.pin_io[PIN_SEL0] && (&q.sel0_hist)
      && !q.sync2[PIN_SEL0];

    d.sync1 = pin_i;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    d.sel0_hist = {q.sel0_hist[1:0], q.sel[0]};
    d.pre = q.mode.clock_divider_bit ? q.pre + 5'd1 : 5'd0;

    if (awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end

    if (rd_go) begin
      case (ra)
        OFF_PIN_IO_ST: rv[PIN_LSB +: 7] = q.pin_io;
        OFF_DRIVE_ST: rv[PIN_LSB +: 7] = q.drive;
        OFF_LEVEL_ST: rv[PIN_LSB +: 7] = q.level;
        OFF_INPUT_ST: rv[PIN_LSB +: 7] = q.sync2;
        OFF_OD_ST: rv[PIN_LSB +: 7] = q.od;
        OFF_GATE_ST: rv[GATE_W-1:0] = q.gate;
        OFF_IRQ_ST: rv[IRQ_W-1:0] = q.irq_mask;
        OFF_MODE: begin
          rv[MR_MASTER] = q.mode.master;
          rv[MR_PS] = q.mode.ps;
          rv[MR_DECODE] = q.mode.decode;
          rv[MR_CLOCK_DIVIDER_BIT] = q.mode.clock_divider_bit;
          rv[MR_CS_LSB +: 4] = q.mode.cs;
        end
        OFF_STATUS: begin
          rv[SR_RX_FULL] = q.rx_full;
          rv[SR_TX_EMPTY] = !q.tx_full;
          rv[SR_FAULT] = q.fault;
          rv[SR_OVERRUN] = q.ovr;
          rv[SR_ENABLED] = q.en;
          d.fault = 1'b0;
          d.ovr = 1'b0;
        end
        OFF_RX_WORD: begin
          rv[15:0] = q.rx_data;
          rv[TX_CS_LSB +: 4] = q.rx_sel;
          d.rx_full = 1'b0;
        end
        default: begin
          if (ra >= OFF_CFG0 && ra <= OFF_CFG3) begin
            rv = q.cfg[ra[3:2]];
          end
        end
      endcase
      d.rvalid = 1'b1;
      d.rdata = rv;
      d.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end

    // write-only registers read as zero; write-one pairs ignore zero bits
    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = mapped(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (wa)
        OFF_PIN_IO_EN: d.pin_io = q.pin_io | w_pins;
        OFF_PIN_IO_DIS: d.pin_io = q.pin_io & ~w_pins;
        OFF_DRIVE_EN: d.drive = q.drive | w_pins;
        OFF_DRIVE_DIS: d.drive = q.drive & ~w_pins;
        OFF_LEVEL_SET: d.level = q.level | w_pins;
        OFF_LEVEL_CLR: d.level = q.level & ~w_pins;
        OFF_OD_EN: d.od = q.od | w_pins;
        OFF_OD_DIS: d.od = q.od & ~w_pins;
        OFF_GATE_EN: d.gate = q.gate | wv[GATE_W-1:0];
        OFF_GATE_DIS: d.gate = q.gate & ~wv[GATE_W-1:0];
        OFF_IRQ_EN: d.irq_mask = q.irq_mask | wv[IRQ_W-1:0];
        OFF_IRQ_DIS: d.irq_mask = q.irq_mask & ~wv[IRQ_W-1:0];
        OFF_CONTROL: begin
          if (wv[CR_ENABLE]) begin
            d.en = 1'b1;
          end
          if (wv[CR_DISABLE]) begin
            d.en = 1'b0;
          end
        end
        OFF_MODE: begin
          if (q.w_strb[0]) begin
            d.mode.master = q.w_data[MR_MASTER];
            d.mode.ps = q.w_data[MR_PS];
            d.mode.decode = q.w_data[MR_DECODE];
            d.mode.clock_divider_bit = q.w_data[MR_CLOCK_DIVIDER_BIT];
          end
          if (q.w_strb[2]) begin
            d.mode.cs = q.w_data[MR_CS_LSB +: 4];
          end
        end
        default: begin
          if (wa >= OFF_CFG0 && wa <= OFF_CFG3) begin
            d.cfg[wa[3:2]] = (q.cfg[wa[3:2]] & ~byte_mask(q.w_strb)) | wv;
          end
        end
      endcase
    end

    case (q.xs)
      X_IDLE: begin
        d.sel = 4'hF;
        d.sck = q.cfg[0].cpol;
        d.cnt = 8'h00;
        d.edges = 6'd0;
        d.rsh = 16'h0000;
        if (q.mode.master && q.en && q.tx_full && !fault_now) begin
          d.xs = X_LEAD;
          d.sel = cs_new;
          d.cfg_idx = cfg_index(cs_new, q.mode.decode);
          d.sck = ncfg.cpol;
          d.sh = q.tx_data << (5'(BITS_MAX) - word_bits(ncfg));
          d.tx_full = 1'b0;
        end else if (!q.mode.master && q.en && !q.sync2[PIN_SEL0]) begin
          d.xs = X_SLAVE;
          d.sh = q.tx_full ? q.tx_data << (5'(BITS_MAX) - word_bits(q.cfg[0])) : 16'h0000;
          d.tx_full = 1'b0;
        end
      end
      X_LEAD: begin
        if (tick) begin
          d.cnt = q.cnt + 8'h01;
          if (q.cnt + 8'h01 >= cur.lead) begin
            d.xs = X_SHIFT;
            d.cnt = 8'h00;
          end
        end
      end
      X_SHIFT: begin
        if (tick) begin
          d.cnt = q.cnt + 8'h01;
          if (q.cnt + 8'h01 >= half) begin
            d.cnt = 8'h00;
            d.sck = !q.sck;
            edge_now = 1'b1;
          end
        end
      end
      X_GAP: begin
        if (tick) begin
          d.cnt = q.cnt + 8'h01;
          if (q.cnt + 8'h01 >= cur.gap) begin
            d.xs = X_IDLE;
            d.cnt = 8'h00;
          end
        end
      end
      X_SLAVE: begin
        edge_now = q.sync2[PIN_CLK] != q.sync3[PIN_CLK];
        if (q.sync2[PIN_SEL0] || !q.en || q.mode.master) begin
          d.xs = X_IDLE;
          edge_now = 1'b0;
        end
      end
      default: d.xs = X_IDLE;
    endcase

    // both sides: sample on one edge, shift on the other, never before the first edge
    if (edge_now) begin
      if (sample) begin
        rsh_new = {q.rsh[14:0], rx_in};
        d.rsh = rsh_new;
      end else if (q.edges != 6'd0) begin
        d.sh = {q.sh[14:0], 1'b0};
      end
      d.edges = q.edges + 6'd1;
      if (q.edges == {nb, 1'b0} - 6'd1) begin
        word_done = 1'b1;
        d.edges = 6'd0;
      end
    end

    if (word_done) begin
      d.rx_data = rsh_new & (16'hFFFF >> (5'(BITS_MAX) - nb));
      d.rx_sel = (q.xs == X_SLAVE) ? q.sync2[PIN_SEL0 +: 4] : q.sel;
      if (q.rx_full && !rx_read) begin
        d.ovr = 1'b1;
      end
      d.rx_full = 1'b1;
      if (q.xs == X_SLAVE) begin
        d.sh = q.tx_full ? q.tx_data << (5'(BITS_MAX) - nb) : 16'h0000;
        d.tx_full = 1'b0;
        d.rsh = 16'h0000;
      end else begin
        d.xs = X_GAP;
        d.sel = 4'hF;
      end
    end

    if (wr_go && wa == OFF_TX_WORD) begin
      d.tx_full = 1'b1;
      d.tx_data = wv[15:0];
      d.tx_cs = wv[TX_CS_LSB +: 4];
    end

    if (fault_now) begin
      d.fault = 1'b1;
      d.en = 1'b0;
      d.xs = X_IDLE;
      d.sel = 4'hF;
    end

    // the transfer controller is only served by an enabled master
    d.req_tx = d.mode.master && d.en && !d.tx_full;
    d.req_rx = d.mode.master && d.en && d.rx_full;

    fn_o = {q.sel, q.sh[15], q.sh[15], q.sck};
    fn_drv = {{4{q.mode.master}}, q.mode.master, !q.mode.master && q.en && !q.sync2[PIN_SEL0],
      q.mode.master};
    for (int i = 0; i < 7; i++) begin
      o_v = q.pin_io[i] ? q.level[i] : fn_o[i];
      drv_v = q.pin_io[i] ? q.drive[i] : fn_drv[i];
      if (q.od[i] && o_v) begin
        drv_v = 1'b0;
      end
      d.pin_o[i] = o_v;
      d.pin_oe_n[i] = !drv_v;
    end

    d.awready = !d.aw_have;
    d.wready = !d.w_have;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.pin_io <= PIN_IO_RST[PIN_LSB +: 7];
      q.pin_oe_n <= 7'h7F;
      q.sel <= 4'hF;
      q.sel0_hist <= 3'h0;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign arready = q.arready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = q.rdata;
  assign pin_o = q.pin_o;
  assign pin_oe_n = q.pin_oe_n;
  assign xfer_req_tx = q.req_tx;
  assign xfer_req_rx = q.req_rx;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_TX_START:
    assert property (q.xs == X_IDLE && q.mode.master && q.en && q.tx_full && !fault_now |=> q.xs == X_LEAD)
      else $error("transmit word did not start a transfer");
  AST_SEL_IDLE_HIGH:
    assert property (q.xs == X_IDLE || q.xs == X_GAP |-> ##1 (q.sel == 4'hF || q.xs == X_LEAD))
      else $error("selects not high outside a transfer");
  AST_OVERRUN:
    assert property (word_done && q.rx_full && !rx_read |=> q.ovr)
      else $error("overrun not flagged");
  AST_FAULT_DISABLES:
    assert property (fault_now |=> q.fault && !q.en && q.xs == X_IDLE)
      else $error("mode fault did not disable the unit");
  AST_NO_SEL_IN_SLAVE:
    assert property ((!q.mode.master && q.pin_io[6:3] == 4'h0) [*2] |-> q.pin_oe_n[6:3] == 4'hF)
      else $error("selects driven outside master mode");
  AST_FIXED_SEL:
    assert property (q.xs == X_IDLE && !q.mode.ps ##1 q.xs == X_LEAD |-> q.sel == $past(q.mode.cs))
      else $error("fixed select field not used");
  AST_VAR_SEL:
    assert property (q.xs == X_IDLE && q.mode.ps ##1 q.xs == X_LEAD |-> q.sel == $past(q.tx_cs))
      else $error("per-word select not used");
  AST_RX_SEL:
    assert property (word_done && q.xs == X_SHIFT |=> q.rx_sel == $past(q.sel) && q.rx_full)
      else $error("select state not captured with word");
  AST_PIN_RESET:
    assert property ($rose(aresetn) |-> q.pin_io == PIN_IO_RST[PIN_LSB +: 7])
      else $error("pin I/O state wrong after reset");
  AST_NO_FAULT_PIO:
    assert property (q.pin_io[PIN_SEL0] |=> !$rose(q.fault))
      else $error("fault flagged while select pin is pin I/O");
  AST_SLAVE_NO_REQ:
    assert property (!q.mode.master [*2] |-> !q.req_tx && !q.req_rx)
      else $error("transfer request raised in slave mode");

  COV_MASTER_WORD: cover property (q.xs == X_SHIFT && word_done);
  COV_SLAVE_WORD: cover property (q.xs == X_SLAVE && word_done);
  COV_FAULT: cover property (fault_now);
  COV_OVERRUN: cover property ($rose(q.ovr));

endmodule
`default_nettype wire

// file: hw/spi_unit_pkg.sv
// spi_unit_pkg: register map, field layouts, reset values and types of the serial unit.
// assumes a 32-bit AXI4-Lite register bus and a single 100 MHz core clock.
package spi_unit_pkg;

  localparam logic [11:0] OFF_PIN_IO_EN = 12'h000;
  localparam logic [11:0] OFF_PIN_IO_DIS = 12'h004;
  localparam logic [11:0] OFF_PIN_IO_ST = 12'h008;
  localparam logic [11:0] OFF_DRIVE_EN = 12'h010;
  localparam logic [11:0] OFF_DRIVE_DIS = 12'h014;
  localparam logic [11:0] OFF_DRIVE_ST = 12'h018;
  localparam logic [11:0] OFF_LEVEL_SET = 12'h030;
  localparam logic [11:0] OFF_LEVEL_CLR = 12'h034;
  localparam logic [11:0] OFF_LEVEL_ST = 12'h038;
  localparam logic [11:0] OFF_INPUT_ST = 12'h03C;
  localparam logic [11:0] OFF_OD_EN = 12'h040;
  localparam logic [11:0] OFF_OD_DIS = 12'h044;
  localparam logic [11:0] OFF_OD_ST = 12'h048;
  localparam logic [11:0] OFF_GATE_EN = 12'h050;
  localparam logic [11:0] OFF_GATE_DIS = 12'h054;
  localparam logic [11:0] OFF_GATE_ST = 12'h058;
  localparam logic [11:0] OFF_CONTROL = 12'h060;
  localparam logic [11:0] OFF_MODE = 12'h064;
  localparam logic [11:0] OFF_STATUS = 12'h070;
  localparam logic [11:0] OFF_IRQ_EN = 12'h074;
  localparam logic [11:0] OFF_IRQ_DIS = 12'h078;
  localparam logic [11:0] OFF_IRQ_ST = 12'h07C;
  localparam logic [11:0] OFF_RX_WORD = 12'h080;
  localparam logic [11:0] OFF_TX_WORD = 12'h084;
  localparam logic [11:0] OFF_CFG0 = 12'h090;
  localparam logic [11:0] OFF_CFG3 = 12'h09C;

  // pin fields sit at bits 22:16 of every pin register
  localparam int PIN_LSB = 16;
  localparam int PIN_CLK = 0;
  localparam int PIN_MISO = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_SEL0 = 3;
  localparam logic [31:0] PIN_IO_RST = 32'h007F0000;

  localparam int CR_ENABLE = 0;
  localparam int CR_DISABLE = 1;
  localparam int MR_MASTER = 0;
  localparam int MR_PS = 1;
  localparam int MR_DECODE = 2;
  localparam int MR_CLOCK_DIVIDER_BIT = 3;
  localparam int MR_CS_LSB = 16;
  localparam int SR_RX_FULL = 0;
  localparam int SR_TX_EMPTY = 1;
  localparam int SR_FAULT = 2;
  localparam int SR_OVERRUN = 3;
  localparam int SR_ENABLED = 16;
  localparam int TX_CS_LSB = 16;
  localparam int GATE_W = 2;
  localparam int IRQ_W = 4;

  localparam int DIV_RATIO = 32;
  localparam int BITS_BASE = 8;
  localparam int BITS_MAX = 16;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] gap;
    logic [7:0] lead;
    logic [7:0] baud;
    logic [3:0] bits;
    logic [1:0] spare;
    logic clock_phase_field;
    logic cpol;
  } sel_cfg_s;

  typedef struct packed {
    logic [3:0] cs;
    logic clock_divider_bit;
    logic decode;
    logic ps;
    logic master;
  } mode_s;

  typedef enum logic [2:0] {
    X_IDLE = 3'b000,
    X_LEAD = 3'b001,
    X_SHIFT = 3'b010,
    X_GAP = 3'b011,
    X_SLAVE = 3'b100
  } xfer_e;

endpackage

// file: tb/spi_far_end.sv
// spi_far_end: behavioural serial slave on the unit's seven pins, able to pull select 0 low or act as master.
// assumes clock idle low, data sampled on the rising edge, msb first, 8-bit words.
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
  input wire logic [6:0] pin_o,
  input wire logic [6:0] pin_oe_n,
  input wire logic [7:0] reply,
  input wire logic pull_sel0,
  input wire logic as_master,
  output logic [6:0] lvl,
  output logic [7:0] seen
);
  logic [7:0] sh = 8'h00;
  logic miso = 1'b0;
  logic [6:0] ext;
  logic sck_m = 1'b1;
  logic mosi_m = 1'b1;
  logic sel_m = 1'b0;
  wire sel_n = &lvl[6:3];
  // selects and clock have pull-ups; wired-and lets a second master win on select 0
  assign ext = {3'b111, ~(pull_sel0 | sel_m), mosi_m, miso | as_master, sck_m};
  assign lvl = (pin_oe_n | pin_o) & ext;
  always @(negedge sel_n) begin
    sh = reply;
    miso = reply[7];
  end
  // a released line must not keep the last bit
  always @(posedge sel_n) miso = ~miso;
  always @(posedge lvl[0]) if (!sel_n) seen = {seen[6:0], as_master ? lvl[1] : lvl[2]};
  // as external master: clock idle low, data changes while the clock is low, 125 ns clock period
  always @(posedge as_master) begin
    sck_m = 1'b0;
    #100 sel_m = 1'b1;
    #100;
    for (int i = 7; i >= 0; i--) begin
      mosi_m = reply[i];
      #62.5 sck_m = 1'b1;
      #62.5 sck_m = 1'b0;
    end
    #100 sel_m = 1'b0;
    sck_m = 1'b1;
    mosi_m = 1'b1;
  end
  always @(negedge lvl[0]) if (!sel_n) begin
    sh = {sh[6:0], 1'b0};
    miso = sh[7];
  end
endmodule
`default_nettype wire

// file: tb/spi_unit_tb_top.sv
// spi_unit_tb_top: register-bus driven bench for the serial unit with a far-end slave model.
// assumes spi_unit_pkg and the 100 MHz core clock; all waits are bounded.
`timescale 1ns/1ps
`default_nettype none
module spi_unit_tb_top;
  import spi_unit_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, pull = 0, ext_master = 0;
  logic awready, wready, bvalid, arready, rvalid, req_tx, req_rx;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] pin_o, pin_oe_n, lvl;
  logic [7:0] reply = 0, seen;
  logic [65:0] notes[$];
  int n_fail = 0, checks = 0;
  localparam logic [31:0] CFG = 32'h02020402;
  spi_unit spi_unit_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pin_i(lvl), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .xfer_req_tx(req_tx), .xfer_req_rx(req_rx));
  spi_far_end spi_far_end_i (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .reply(reply), .pull_sel0(pull),
    .as_master(ext_master), .lvl(lvl), .seen(seen));
  initial forever #5 aclk = ~aclk;
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d of %0d compares", n_fail, checks);
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 3000) begin
      n_fail++;
      report_and_stop;
    end
  endtask
  // the note queue pairs each read with its expected {mask, resp, data}
  always @(posedge aclk) if (rvalid && rready) begin
    logic [65:0] t;
    t = notes.pop_front();
    chk({rresp, rdata & t[65:34]}, {t[33:32], t[31:0] & t[65:34]});
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    int n;
    n = 0;
    rb = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!rb && n < 3000) begin
      @(negedge aclk);
      ra = awready;
      rw = wready;
      rb = bvalid;
      @(posedge aclk);
      if (ra) awvalid <= 0;
      if (rw) wvalid <= 0;
      if (rb) bready <= 0;
      n++;
    end
    bound(n);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    logic ra, rv;
    int n;
    n = 0;
    rv = 0;
    notes.push_back({m, r, e});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!rv && n < 3000) begin
      @(negedge aclk);
      ra = arready;
      rv = rvalid;
      @(posedge aclk);
      if (ra) arvalid <= 0;
      if (rv) rready <= 0;
      n++;
    end
    bound(n);
  endtask
  task automatic wait_frame;
    int n;
    n = 0;
    while (lvl[6:3] == 4'hF && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    while (lvl[6:3] != 4'hF && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    bound(n);
  endtask
  initial begin
    void'($urandom(32'hc683));
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(OFF_PIN_IO_ST, PIN_IO_RST, '1, RESP_OKAY);
    rd(OFF_OD_ST, 0, '1, RESP_OKAY);
    rd(12'h00C, 0, 0, RESP_SLVERR);
    wr(OFF_PIN_IO_DIS, 32'h007F0000);
    rd(OFF_PIN_IO_ST, 0, '1, RESP_OKAY);
    wr(OFF_OD_EN, 32'h00100000);
    wr(OFF_OD_EN, 32'h0);
    rd(OFF_OD_ST, 32'h00100000, '1, RESP_OKAY);
    wr(OFF_OD_DIS, 32'h00100000);
    // select 1 gets a 9-bit word so that a switch of configuration shows in the received data
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CFG0 + 12'(4 * i), CFG | (i == 1 ? 32'h10 : 32'h0));
      rd(OFF_CFG0 + 12'(4 * i), CFG | (i == 1 ? 32'h10 : 32'h0), '1, RESP_OKAY);
    end
    // undivided clock is safe here because select 0 is never open drain
    wr(OFF_MODE, 32'h000E0001);
    wr(OFF_CONTROL, 32'h1);
    reply <= 8'($urandom);
    wr(OFF_TX_WORD, 32'hA5);
    wr(OFF_TX_WORD, 32'h3C);
    wait_frame;
    wait_frame;
    chk(seen, 8'h3C);
    chk(lvl[6:3], 4'hF);
    chk({req_tx, req_rx}, 2'b11);
    rd(OFF_STATUS, 32'h9, 32'h9, RESP_OKAY);
    rd(OFF_RX_WORD, {12'h0, 4'hE, 8'h0, reply}, 32'h000F00FF, RESP_OKAY);
    rd(OFF_STATUS, 0, 32'h8, RESP_OKAY);
    wr(OFF_MODE, 32'h000E0003);
    wr(OFF_TX_WORD, 32'h000D0055);
    wait_frame;
    rd(OFF_RX_WORD, {12'h0, 4'hD, 7'h0, reply, 1'b0}, 32'h000F01FF, RESP_OKAY);
    // fixed select, decoded lines and the slow clock: code 6 picks configuration 1
    wr(OFF_MODE, 32'h0006000D);
    wr(OFF_TX_WORD, 32'h77);
    wait_frame;
    rd(OFF_RX_WORD, {12'h0, 4'h6, 7'h0, reply, 1'b0}, 32'h000F01FF, RESP_OKAY);
    wr(OFF_PIN_IO_EN, 32'h00080000);
    pull <= 1;
    repeat (10) @(posedge aclk);
    rd(OFF_STATUS, 0, 32'h4, RESP_OKAY);
    wr(OFF_PIN_IO_DIS, 32'h00080000);
    repeat (10) @(posedge aclk);
    rd(OFF_STATUS, 32'h4, 32'h10004, RESP_OKAY);
    pull <= 0;
    rd(OFF_STATUS, 0, 32'h10004, RESP_OKAY);
    wr(OFF_MODE, 32'h0);
    wr(OFF_CONTROL, 32'h1);
    wr(OFF_TX_WORD, 32'hC3);
    ext_master <= 1;
    wait_frame;
    chk(seen, 8'hC3);
    chk({req_tx, req_rx}, 2'b00);
    rd(OFF_RX_WORD, {12'h0, 4'hE, 8'h0, reply}, 32'h000F00FF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    report_and_stop;
  end
endmodule
`default_nettype wire
